// ---- src/ioc_pkg.sv ----
// constants for the four-pad programmable io cell
package ioc_pkg;
   localparam int NPAD = 4;
   localparam int AW   = 3;
   localparam int DW   = 8;

   // register indices
   localparam logic [AW-1:0] REG_PAD0   = 3'h0;
   localparam logic [AW-1:0] REG_PAD3   = 3'h3;
   localparam logic [AW-1:0] REG_OUTCTL = 3'h4;
   localparam logic [AW-1:0] REG_SRCCTL = 3'h5;
   localparam logic [AW-1:0] REG_LEVEL  = 3'h6;
   localparam logic [AW-1:0] REG_STATUS = 3'h7;

   // per-pad config byte
   localparam int CFG_MODE_LSB = 0;
   localparam int CFG_IDLY_BIT = 2;
   localparam int CFG_DDLY_BIT = 3;
   localparam int CFG_PULL_LSB = 4;
   localparam int CFG_SPD_LSB  = 6;

   // outctl / srcctl / status fields
   localparam int OUT_INV_LSB = 0;
   localparam int OUT_TSL_LSB = 4;
   localparam int SRC_DIR_LSB = 0;
   localparam int SRC_CKS_LSB = 4;
   localparam int SRC_CKE_BIT = 6;
   localparam int STA_OE_LSB  = 4;

   localparam logic [1:0] MODE_IN   = 2'h0;
   localparam logic [1:0] MODE_OUT  = 2'h1;
   localparam logic [1:0] MODE_BIDI = 2'h2;

   localparam logic [1:0] PULL_NONE = 2'h0;
   localparam logic [1:0] PULL_UP   = 2'h1;
   localparam logic [1:0] PULL_DN   = 2'h2;

   localparam logic [1:0] SPD_FAST = 2'h0;
   localparam logic [1:0] SPD_SLEW = 2'h1;
   localparam logic [1:0] SPD_SINK = 2'h2;

   // input mode, pull-up, slew-limited, no delays
   localparam logic [DW-1:0] CFG_RST    = 8'h50;
   localparam logic [DW-1:0] OUTCTL_RST = 8'h00;
   localparam logic [DW-1:0] SRCCTL_RST = 8'h00;
   localparam logic [3:0]    LEVEL_RST  = 4'h0;
   localparam logic [3:0]    SYNC_RST   = 4'hf;
endpackage : ioc_pkg

// ---- src/ioc_sync.sv ----
// three-stage pad synchroniser with agreement filter
module ioc_sync (
   input  wire logic                      clk_i,
   input  wire logic                      rstn_i,
   input  wire logic [ioc_pkg::NPAD-1:0]  d_i,
   output logic      [ioc_pkg::NPAD-1:0]  q_o
);
   import ioc_pkg::*;

   typedef struct packed {
      logic [NPAD-1:0] s1;
      logic [NPAD-1:0] s2;
      logic [NPAD-1:0] s3;
      logic [NPAD-1:0] q;
   } ioc_sync_t;

   ioc_sync_t st_ff;
   ioc_sync_t nxt_st;

   always_comb begin
      nxt_st    = st_ff;
      nxt_st.s1 = d_i;
      nxt_st.s2 = st_ff.s1;
      nxt_st.s3 = st_ff.s2;
      // take the level only when stages two and three agree
      nxt_st.q  = (st_ff.s2 & ~(st_ff.s2 ^ st_ff.s3))
                | (st_ff.q & (st_ff.s2 ^ st_ff.s3));
   end

   always_ff @(posedge clk_i or negedge rstn_i) begin
      if (!rstn_i) begin
         st_ff <= {SYNC_RST, SYNC_RST, SYNC_RST, SYNC_RST};
      end else begin
         st_ff <= nxt_st;
      end
   end

   assign q_o = st_ff.q;
endmodule // ioc_sync

// ---- src/ioc_cell.sv ----
// four-pad programmable io cell with config registers
module ioc_cell (
   input  wire logic                      clk_i,
   input  wire logic                      rstn_i,
   input  wire logic [ioc_pkg::AW-1:0]    addr_i,
   input  wire logic [ioc_pkg::DW-1:0]    wdata_i,
   input  wire logic                      wr_i,
   input  wire logic                      rd_i,
   output logic      [ioc_pkg::DW-1:0]    rdata_o,
   input  wire logic [ioc_pkg::NPAD-1:0]  pad_i,
   output logic      [ioc_pkg::NPAD-1:0]  pad_o,
   output logic      [ioc_pkg::NPAD-1:0]  pad_oe_o,
   output logic      [ioc_pkg::NPAD-1:0]  pull_up_o,
   output logic      [ioc_pkg::NPAD-1:0]  pull_dn_o,
   output logic      [2*ioc_pkg::NPAD-1:0] speed_o,
   output logic      [ioc_pkg::NPAD-1:0]  lvl_cmos_o,
   input  wire logic [ioc_pkg::NPAD-1:0]  gen_out_i,
   input  wire logic [ioc_pkg::NPAD-1:0]  dir_out_i,
   input  wire logic [ioc_pkg::NPAD-1:0]  oe_ctl_i,
   output logic      [ioc_pkg::NPAD-1:0]  gen_in_o,
   output logic      [ioc_pkg::NPAD-1:0]  dir_in_o,
   output logic      [ioc_pkg::NPAD-1:0]  tri_in_o,
   output logic                           clk_line_o
);
   import ioc_pkg::*;

   typedef struct packed {
      logic [NPAD-1:0][DW-1:0] cfg;
      logic [DW-1:0]           outctl;
      logic [DW-1:0]           srcctl;
      logic [3:0]              level;
      logic [NPAD-1:0]         gen_d;
      logic [NPAD-1:0]         dir_d;
      logic [NPAD-1:0]         gen_in;
      logic [NPAD-1:0]         dir_in;
      logic [NPAD-1:0]         tri_in;
      logic                    ck_line;
      logic [NPAD-1:0]         dat_p1;
      logic [NPAD-1:0]         dat_p2;
      logic [NPAD-1:0]         oe_p1;
      logic [NPAD-1:0]         oe_p2;
      logic [NPAD-1:0]         pad;
      logic [NPAD-1:0]         pad_oe;
      logic [NPAD-1:0]         pull_up;
      logic [NPAD-1:0]         pull_dn;
      logic [2*NPAD-1:0]       speed;
      logic [DW-1:0]           rdata;
   } ioc_cell_t;

   ioc_cell_t st_ff;
   ioc_cell_t nxt_st;

   logic [NPAD-1:0]   sync;
   logic [NPAD-1:0]   idly;
   logic [NPAD-1:0]   ddly;
   logic [NPAD-1:0]   drv_dat;
   logic [NPAD-1:0]   drv_en;
   logic [NPAD-1:0]   out_dat;
   logic [NPAD-1:0]   out_en;
   logic [NPAD-1:0]   pu_w;
   logic [NPAD-1:0]   pd_w;
   logic [NPAD-1:0]   is_out;
   logic [NPAD-1:0][1:0] spd_w;
   logic [1:0]        ck_sel;

   ioc_sync u_sync (
      .clk_i  (clk_i),
      .rstn_i (rstn_i),
      .d_i    (pad_i),
      .q_o    (sync)
   );

   assign ck_sel = st_ff.srcctl[SRC_CKS_LSB +: 2];

   // per-pad output and option decode
   for (genvar i = 0; i < NPAD; i++) begin : g_pad
      logic [1:0] mode;
      logic [1:0] pull;
      logic       src;
      logic       ts_act;
      assign mode = st_ff.cfg[i][CFG_MODE_LSB +: 2];
      assign pull = st_ff.cfg[i][CFG_PULL_LSB +: 2];
      assign spd_w[i] = st_ff.cfg[i][CFG_SPD_LSB +: 2];
      assign idly[i] = st_ff.cfg[i][CFG_IDLY_BIT];
      assign ddly[i] = st_ff.cfg[i][CFG_DDLY_BIT];
      assign is_out[i] = (mode == MODE_OUT) || (mode == MODE_BIDI);
      assign src = st_ff.srcctl[SRC_DIR_LSB + i] ? dir_out_i[i]
                                                  : gen_out_i[i];
      assign drv_dat[i] = src ^ st_ff.outctl[OUT_INV_LSB + i];
      assign ts_act = oe_ctl_i[i] ^ st_ff.outctl[OUT_TSL_LSB + i];
      // open-drain when fabric ties data and 3-state together
      assign drv_en[i] = is_out[i] & ~ts_act;
      assign pu_w[i] = (pull == PULL_UP);
      assign pd_w[i] = (pull == PULL_DN);
      // sink-limited is the slowest path
      assign out_dat[i] = (spd_w[i] == SPD_FAST) ? drv_dat[i] :
                          (spd_w[i] == SPD_SLEW) ? st_ff.dat_p1[i] :
                                                   st_ff.dat_p2[i];
      assign out_en[i]  = (spd_w[i] == SPD_FAST) ? drv_en[i] :
                          (spd_w[i] == SPD_SLEW) ? st_ff.oe_p1[i] :
                                                   st_ff.oe_p2[i];
   end

   always_comb begin
      nxt_st = st_ff;
      // inputs follow the pad in every mode
      nxt_st.gen_d  = sync;
      nxt_st.dir_d  = sync;
      nxt_st.gen_in = (idly & st_ff.gen_d) | (~idly & sync);
      nxt_st.dir_in = (ddly & st_ff.dir_d) | (~ddly & sync);
      nxt_st.tri_in = sync;
      nxt_st.ck_line = st_ff.srcctl[SRC_CKE_BIT] & sync[ck_sel];
      nxt_st.dat_p1 = drv_dat;
      nxt_st.dat_p2 = st_ff.dat_p1;
      nxt_st.oe_p1  = drv_en;
      nxt_st.oe_p2  = st_ff.oe_p1;
      nxt_st.pad    = out_dat;
      nxt_st.pad_oe = out_en;
      nxt_st.pull_up = pu_w;
      nxt_st.pull_dn = pd_w;
      nxt_st.speed   = spd_w;
      nxt_st.rdata   = '0;
      if (wr_i) begin
         if (addr_i <= REG_PAD3) begin
            nxt_st.cfg[addr_i[1:0]] = wdata_i;
         end else if (addr_i == REG_OUTCTL) begin
            nxt_st.outctl = wdata_i;
         end else if (addr_i == REG_SRCCTL) begin
            nxt_st.srcctl = wdata_i;
         end else if (addr_i == REG_LEVEL) begin
            nxt_st.level = wdata_i[3:0];
         end
      end
      if (rd_i) begin
         case (addr_i)
            REG_OUTCTL: nxt_st.rdata = st_ff.outctl;
            REG_SRCCTL: nxt_st.rdata = st_ff.srcctl;
            REG_LEVEL:  nxt_st.rdata = {4'h0, st_ff.level};
            REG_STATUS: nxt_st.rdata = {st_ff.pad_oe, sync};
            default:    nxt_st.rdata = st_ff.cfg[addr_i[1:0]];
         endcase
      end
   end

   always_ff @(posedge clk_i or negedge rstn_i) begin
      if (!rstn_i) begin
         st_ff         <= '0;
         st_ff.cfg     <= {CFG_RST, CFG_RST, CFG_RST, CFG_RST};
         st_ff.outctl  <= OUTCTL_RST;
         st_ff.srcctl  <= SRCCTL_RST;
         st_ff.level   <= LEVEL_RST;
         st_ff.gen_d   <= SYNC_RST;
         st_ff.dir_d   <= SYNC_RST;
         st_ff.gen_in  <= SYNC_RST;
         st_ff.dir_in  <= SYNC_RST;
         st_ff.tri_in  <= SYNC_RST;
         st_ff.pull_up <= {NPAD{1'b1}};
         st_ff.speed   <= {SPD_SLEW, SPD_SLEW, SPD_SLEW, SPD_SLEW};
      end else begin
         st_ff <= nxt_st;
      end
   end

   assign rdata_o    = st_ff.rdata;
   assign pad_o      = st_ff.pad;
   assign pad_oe_o   = st_ff.pad_oe;
   assign pull_up_o  = st_ff.pull_up;
   assign pull_dn_o  = st_ff.pull_dn;
   assign speed_o    = st_ff.speed;
   assign lvl_cmos_o = st_ff.level;
   assign gen_in_o   = st_ff.gen_in;
   assign dir_in_o   = st_ff.dir_in;
   assign tri_in_o   = st_ff.tri_in;
   assign clk_line_o = st_ff.ck_line;

   // checks
   default clocking cb @(posedge clk_i); endclocking
   default disable iff (!rstn_i);

   sequence s_two_steady;
      $stable(idly) ##1 $stable(idly);
   endsequence

   a_gen_delay_path: assert property (
      s_two_steady |-> gen_in_o ==
         (($past(sync, 2) & idly) | ($past(sync) & ~idly)))
      else $error("general input delay path wrong");

   a_tri_undelayed: assert property (
      ##1 tri_in_o == $past(sync))
      else $error("tristate buffer input delayed");

   a_ck_fast_path: assert property (
      $past(st_ff.srcctl[SRC_CKE_BIT]) |->
         clk_line_o == $past(sync[ck_sel]))
      else $error("clock line not fed by selected pad");

   a_dir_delay_path: assert property (
      $stable(ddly) ##1 $stable(ddly) |-> dir_in_o ==
         (($past(sync, 2) & ddly) | ($past(sync) & ~ddly)))
      else $error("direct input delay path wrong");

   a_pull_select: assert property (
      ##1 pull_up_o == $past(pu_w) && pull_dn_o == $past(pd_w)
         && (pull_up_o & pull_dn_o) == '0)
      else $error("pull selection wrong");

   a_reset_default: assert property (
      $rose(rstn_i) |-> speed_o == {NPAD{SPD_SLEW}}
         && pull_up_o == {NPAD{1'b1}} && lvl_cmos_o == '0)
      else $error("power-up defaults wrong");

   a_read_data: assert property (
      rd_i && addr_i == REG_OUTCTL && !wr_i ##1 1'b1 |->
         rdata_o == $past(st_ff.outctl))
      else $error("read data wrong");

   for (genvar k = 0; k < NPAD; k++) begin : g_chk
      a_sink_latency: assert property (
         (spd_w[k] == SPD_SINK) [*4] |-> pad_o[k] == $past(drv_dat[k], 3))
         else $error("sink-limited latency wrong");

      a_fast_sense: assert property (
         (spd_w[k] == SPD_FAST) [*2] |->
            pad_oe_o[k] == $past(is_out[k] &
               ~(oe_ctl_i[k] ^ st_ff.outctl[OUT_TSL_LSB + k])))
         else $error("3-state polarity wrong");

      a_hiz_input: assert property (
         (!is_out[k]) [*4] |-> !pad_oe_o[k])
         else $error("undriven pad not high-Z");
   end
endmodule // ioc_cell

// ---- verification/ioc_board.sv ----
// board side of the pads: drivers, pulls and floating nets
module ioc_board
   import ioc_pkg::*;
(
   input  wire logic                     clk_i,
   input  wire logic [ioc_pkg::NPAD-1:0] drv_i,
   input  wire logic [ioc_pkg::NPAD-1:0] oe_i,
   input  wire logic [ioc_pkg::NPAD-1:0] up_i,
   input  wire logic [ioc_pkg::NPAD-1:0] dn_i,
   input  wire logic [ioc_pkg::NPAD-1:0] ext_en_i,
   input  wire logic [ioc_pkg::NPAD-1:0] ext_val_i,
   output logic      [ioc_pkg::NPAD-1:0] pad_o
);
   logic [NPAD-1:0] float_ff = '0;

   // an undriven, unpulled net wanders every cycle
   always @(posedge clk_i) begin
      float_ff <= ~float_ff;
   end

   always_comb begin
      for (int i = 0; i < NPAD; i++) begin
         if (oe_i[i])
            pad_o[i] = drv_i[i];
         else if (ext_en_i[i])
            pad_o[i] = ext_val_i[i];
         else if (up_i[i])
            pad_o[i] = 1'b1;
         else if (dn_i[i])
            pad_o[i] = 1'b0;
         else
            pad_o[i] = float_ff[i];
      end
   end
endmodule // ioc_board

// ---- verification/ioc_cell_test.sv ----
// self-checking bench for the four-pad io cell
module ioc_cell_test;
   timeunit 1ns;
   timeprecision 1ps;
   import ioc_pkg::*;
   logic          clk_i, rstn_i, wr_i, rd_i, clk_line_o;
   logic [AW-1:0] addr_i;
   logic [DW-1:0] wdata_i, rdata_o, speed_o, sp;
   logic [3:0]    pad_i, pad_o, pad_oe_o, pull_up_o, pull_dn_o, lvl_cmos_o;
   logic [3:0]    gen_out_i, dir_out_i, oe_ctl_i, gen_in_o, dir_in_o;
   logic [3:0]    tri_in_o, ext_en, ext_val, d, oe, l, n;
   int            n_errors, samples_checked, cyc, cp, mregs[8];
   int            lt[4], lg[4], ld[4], lc;

   ioc_cell i_ioc_cell (.clk_i, .rstn_i, .addr_i, .wdata_i, .wr_i, .rd_i,
      .rdata_o, .pad_i, .pad_o, .pad_oe_o, .pull_up_o, .pull_dn_o, .speed_o,
      .lvl_cmos_o, .gen_out_i, .dir_out_i, .oe_ctl_i, .gen_in_o, .dir_in_o,
      .tri_in_o, .clk_line_o);
   ioc_board i_ioc_board (.clk_i, .drv_i(pad_o), .oe_i(pad_oe_o),
      .up_i(pull_up_o), .dn_i(pull_dn_o), .ext_en_i(ext_en),
      .ext_val_i(ext_val), .pad_o(pad_i));

   initial begin
      clk_i = 1'b0;
      forever #12.5 clk_i = ~clk_i;
   end

   task automatic final_report();
      $display("checks %0d errors %0d", samples_checked, n_errors);
      if (n_errors == 0 && samples_checked > 0)
         $display("ALL TESTS PASSED");
      else
         $display("TESTS FAILED");
      $finish;
   endtask

   always @(posedge clk_i) begin
      cyc++;
      if (cyc == 20000) begin
         n_errors++;
         final_report();
      end
   end

   task automatic check(string nm, logic [7:0] seen, logic [7:0] exp);
      samples_checked++;
      if (seen !== exp) begin
         n_errors++;
         $display("MISMATCH %s exp %h seen %h", nm, exp, seen);
      end
   endtask

   task automatic wr(int a, int v);
      @(posedge clk_i);
      addr_i <= a[AW-1:0];
      wdata_i <= v[7:0];
      wr_i <= 1'b1;
      @(posedge clk_i);
      wr_i <= 1'b0;
      if (a != 7) mregs[a] = v & 8'hff;
   endtask

   task automatic rd(int a, logic [7:0] exp);
      @(posedge clk_i);
      addr_i <= a[AW-1:0];
      rd_i <= 1'b1;
      @(posedge clk_i);
      rd_i <= 1'b0;
      #1 check("rdata", rdata_o, exp);
      @(posedge clk_i);
      #1 check("rdata_idle", rdata_o, 8'h00);
   endtask

   // expected drive, enable and pad level from the shadow registers
   task automatic model();
      for (int i = 0; i < 4; i++) begin
         d[i] = (mregs[5][i] ? dir_out_i[i] : gen_out_i[i]) ^ mregs[4][i];
         oe[i] = (mregs[i][1:0] inside {1, 2}) &&
                 (oe_ctl_i[i] == mregs[4][4+i]);
         l[i] = oe[i] ? d[i] : ext_en[i] ? ext_val[i] : mregs[i][4];
         sp[2*i+:2] = mregs[i][7:6];
      end
   endtask

   initial begin
      rstn_i = 1'b0;
      {wr_i, rd_i, addr_i, wdata_i, ext_en, ext_val} = '0;
      {gen_out_i, dir_out_i, oe_ctl_i} = '0;
      mregs = '{8'h50, 8'h50, 8'h50, 8'h50, 0, 0, 0, 0};
      void'($urandom(56992));
      repeat (6) @(posedge clk_i);
      rstn_i <= 1'b1;
      #1 check("rst_oe", pad_oe_o, 8'h0);
      check("rst_spd", speed_o, 8'h55);
      check("rst_up", {pull_dn_o, pull_up_o}, 8'h0f);
      check("rst_lvl", lvl_cmos_o, 8'h0);
      repeat (6) @(posedge clk_i);
      #1 check("rst_in", gen_in_o, 8'h0f);
      for (int a = 0; a < 7; a++) rd(a, mregs[a][7:0]);
      wr(7, 8'h00);
      rd(7, 8'h0f);
      repeat (24) begin
         for (int i = 0; i < 4; i++)
            wr(i, $urandom % 4 | ($urandom % 3) << 4 | ($urandom % 4) << 6
               | ($urandom % 4) << 2);
         wr(4, $urandom);
         wr(5, $urandom);
         wr(6, $urandom % 16);
         gen_out_i <= 4'($urandom);
         dir_out_i <= 4'($urandom);
         oe_ctl_i <= 4'($urandom);
         ext_val <= 4'($urandom);
         for (int i = 0; i < 4; i++)
            ext_en[i] <= 1'($urandom % 2) | (mregs[i][5:4] == 0);
         repeat (10) @(posedge clk_i);
         #1 model();
         check("oe", pad_oe_o, oe);
         check("pad", pad_o & oe, d & oe);
         check("gen_in", gen_in_o, l);
         check("tri_in", tri_in_o, l);
         check("dir_in", dir_in_o, l);
         check("speed", speed_o, sp);
         check("up", pull_up_o, {mregs[3][4], mregs[2][4],
            mregs[1][4], mregs[0][4]});
         check("dn", pull_dn_o, {mregs[3][5], mregs[2][5],
            mregs[1][5], mregs[0][5]});
         check("lvl", lvl_cmos_o, mregs[6][3:0]);
         check("clk", clk_line_o, mregs[5][6] & l[mregs[5][5:4]]);
         rd(7, {oe, l});
         cp = $urandom % 7;
         rd(cp, mregs[cp][7:0]);
      end
      for (int s = 0; s < 3; s++) begin
         for (int i = 0; i < 4; i++) wr(i, 8'h11 | s << 6);
         wr(4, 0);
         wr(5, 0);
         oe_ctl_i <= 4'h0;
         gen_out_i <= 4'h5;
         repeat (6) @(posedge clk_i);
         gen_out_i <= 4'ha;
         repeat (s) @(posedge clk_i);
         #1 check("early", pad_o, 8'h05);
         @(posedge clk_i);
         #1 check("late", pad_o, 8'h0a);
      end
      repeat (4) begin
         @(posedge clk_i);
         n = 4'($urandom);
         ext_en <= 4'h0;
         gen_out_i <= n;
         oe_ctl_i <= n;
         repeat (4) @(posedge clk_i);
         #1 check("od_oe", pad_oe_o, 4'(~n));
         check("od_lvl", pad_i, n);
      end
      for (int i = 0; i < 4; i++) wr(i, 8'h10 | i << 2);
      cp = $urandom % 4;
      wr(5, 8'h40 | cp << 4);
      ext_en <= 4'hf;
      ext_val <= 4'h0;
      repeat (8) @(posedge clk_i);
      ext_val <= 4'hf;
      lt = '{default:0};
      lg = '{default:0};
      ld = '{default:0};
      lc = 0;
      for (int c = 1; c < 13; c++) begin
         @(posedge clk_i);
         #1;
         for (int i = 0; i < 4; i++) begin
            if (!lt[i] && tri_in_o[i] === 1'b1) lt[i] = c;
            if (!lg[i] && gen_in_o[i] === 1'b1) lg[i] = c;
            if (!ld[i] && dir_in_o[i] === 1'b1) ld[i] = c;
         end
         if (!lc && clk_line_o === 1'b1) lc = c;
      end
      for (int i = 0; i < 4; i++) begin
         check("tri_seen", 8'(lt[i] != 0), 8'h1);
         check("gen_lag", 8'(lg[i] - lt[i]), 8'(i & 1));
         check("dir_lag", 8'(ld[i] - lt[i]), 8'(i >> 1));
      end
      check("clk_lag", 8'(lc - lt[cp]), 8'h0);
      final_report();
   end
endmodule // ioc_cell_test
